// ---- verilog/flash_cfg.svh ----
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH
`define KEY_FIRST        8'ha5
`define KEY_SECOND       8'hf1
`define ERASED_BYTE      8'hff
`define PAGE_BYTES       512
`define PAGE_BITS        9
`define SHORT_ADDR_MAX   16'h00ff
`define FLASH_BYTES      32768
`define DATA_RAM_BYTES   2048
`define PROG_CYCLES      16
`define WRITE_EN_BIT     0
`define ERASE_EN_BIT     1
`define TIMING_BIT       4
`define CTRL_RESET       1'b0
`define REG_ADDR         8'h00
`define REG_WDATA        8'h04
`define REG_CMD          8'h08
`define REG_STATUS       8'h0c
`define CMD_OP_LSB       0
`define CMD_SEL_LSB      4
`define CMD_SHORT_BIT    8
`define ST_BUSY_BIT      0
`define ST_WRITE_EN_BIT  1
`define ST_ERASE_EN_BIT  2
`define ST_TIMING_BIT    3
`define ST_ARMED_BIT     4
`define ST_DEAD_BIT      5
`define ST_RDATA_LSB     8
`endif

// ---- verilog/flash_pkg.sv ----
package flash_pkg;
  typedef enum logic [1:0] {op_sfr_wr, op_xm_wr, op_xm_rd, op_code_rd} op_t;
  typedef enum logic [1:0] {sfr_key, sfr_ctrl, sfr_scale, sfr_spare} sfr_t;
endpackage : flash_pkg

// ---- verilog/flash_if.sv ----
`timescale 1ns/10ps
interface flash_if;
  logic              req;
  flash_pkg::op_t    op;
  flash_pkg::sfr_t   sel;
  logic [15:0]       addr;
  logic [7:0]        wdata;
  logic              short_form;
  logic              stall;
  logic [7:0]        rdata;
  logic              program_store_write_enable;
  logic              program_store_erase_enable;
  logic              flash_erase_write_timing_bit;
  logic              armed;
  logic              dead;
  modport device (
    input  req, op, sel, addr, wdata, short_form,
    output stall, rdata, program_store_write_enable, program_store_erase_enable,
           flash_erase_write_timing_bit, armed, dead
  );
  modport core (
    output req, op, sel, addr, wdata, short_form,
    input  stall, rdata, program_store_write_enable, program_store_erase_enable,
           flash_erase_write_timing_bit, armed, dead
  );
endinterface : flash_if

// ---- verilog/flash_key_lock.sv ----
`timescale 1ns/10ps
`include "flash_cfg.svh"
module flash_key_lock (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_val,
  input  wire logic       op_try,
  output logic            armed,
  output logic            dead
);
  typedef enum logic [1:0] {lk_closed, lk_half, lk_open, lk_dead} lock_state_t;
  lock_state_t state_q;
  lock_state_t state_d;

  // No timer anywhere: only order and value decide
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      lk_closed: begin
        if (op_try) state_d = lk_dead;
        else if (key_wr) state_d = (key_val == `KEY_FIRST) ? lk_half : lk_dead;
      end
      lk_half: begin
        if (op_try) state_d = lk_dead;
        else if (key_wr) state_d = (key_val == `KEY_SECOND) ? lk_open : lk_dead;
      end
      lk_open: begin
        if (op_try) state_d = lk_closed;
        else if (key_wr) state_d = lk_dead;
      end
      lk_dead: state_d = lk_dead;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) state_q <= lk_closed;
    else state_q <= state_d;
  end

  assign armed = (state_q == lk_open);
  assign dead  = (state_q == lk_dead);
endmodule : flash_key_lock

// ---- verilog/flash_device.sv ----
`timescale 1ns/10ps
`include "flash_cfg.svh"
module flash_device #(
  parameter int FLASH_BYTES    = `FLASH_BYTES,
  parameter int DATA_RAM_BYTES = `DATA_RAM_BYTES,
  parameter int PROG_CYCLES    = `PROG_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  flash_if.device   bus,
  output logic      flash_busy,
  output logic      op_done,
  output logic      lock_dead
);
  localparam int FA = $clog2(FLASH_BYTES);
  localparam int XA = $clog2(DATA_RAM_BYTES);

  typedef enum logic [1:0] {st_idle, st_prog, st_erase} dev_state_t;

  logic [7:0]    flash_mem         [FLASH_BYTES];
  logic [7:0]    external_data_ram [DATA_RAM_BYTES];

  dev_state_t    state_q;
  dev_state_t    state_d;
  logic [15:0]   cnt_q;
  logic [15:0]   cnt_d;
  logic [FA-1:0] tgt_q;
  logic [FA-1:0] tgt_d;
  logic [7:0]    dat_q;
  logic [7:0]    dat_d;
  logic          program_store_write_enable_q;
  logic          program_store_write_enable_d;
  logic          program_store_erase_enable_q;
  logic          program_store_erase_enable_d;
  logic          flash_erase_write_timing_bit_q;
  logic          flash_erase_write_timing_bit_d;
  logic [7:0]    rdata_q;
  logic [7:0]    rdata_d;
  logic          done_q;
  logic          done_d;

  logic          take;
  logic          key_wr;
  logic          op_try;
  logic          armed;
  logic          dead;
  logic          fl_we;
  logic [FA-1:0] fl_wa;
  logic [7:0]    fl_wd;
  logic          xr_we;
  logic [XA-1:0] xr_wa;
  logic [7:0]    xr_wd;
  logic          addr_ok;

  flash_key_lock u_lock (
    .hclk    (hclk),
    .hresetn (hresetn),
    .key_wr  (key_wr),
    .key_val (bus.wdata),
    .op_try  (op_try),
    .armed   (armed),
    .dead    (dead)
  );

  // Requests are only taken while no operation runs
  assign take = bus.req && (state_q == st_idle);

  // Short form cannot write flash above the low 256 bytes; code reads ignore it
  assign addr_ok = !bus.short_form || (bus.addr <= `SHORT_ADDR_MAX);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    tgt_d   = tgt_q;
    dat_d   = dat_q;
    program_store_write_enable_d   = program_store_write_enable_q;
    program_store_erase_enable_d   = program_store_erase_enable_q;
    flash_erase_write_timing_bit_d = flash_erase_write_timing_bit_q;
    rdata_d = rdata_q;
    done_d  = 1'b0;
    key_wr  = 1'b0;
    op_try  = 1'b0;
    fl_we   = 1'b0;
    fl_wa   = tgt_q;
    fl_wd   = dat_q;
    xr_we   = 1'b0;
    xr_wa   = bus.addr[XA-1:0];
    xr_wd   = bus.wdata;
    unique case (state_q)
      st_idle: begin
        if (take) begin
          unique case (bus.op)
            flash_pkg::op_sfr_wr: begin
              unique case (bus.sel)
                flash_pkg::sfr_key:   key_wr = 1'b1;
                // Enables change only here, never by an operation
                flash_pkg::sfr_ctrl: begin
                  program_store_write_enable_d = bus.wdata[`WRITE_EN_BIT];
                  program_store_erase_enable_d = bus.wdata[`ERASE_EN_BIT];
                end
                flash_pkg::sfr_scale: flash_erase_write_timing_bit_d = bus.wdata[`TIMING_BIT];
                default: ;
              endcase
            end
            flash_pkg::op_xm_wr: begin
              if (!program_store_write_enable_q) begin
                xr_we = 1'b1;
              end else if (addr_ok && !dead) begin
                op_try = 1'b1;
                if (armed) begin
                  tgt_d = bus.addr[FA-1:0];
                  dat_d = bus.wdata;
                  cnt_d = 16'h0000;
                  if (program_store_erase_enable_q) begin
                    // Low bits dropped: any byte of the page selects it
                    tgt_d[`PAGE_BITS-1:0] = '0;
                    state_d = st_erase;
                  end else begin
                    state_d = st_prog;
                  end
                end
              end
            end
            flash_pkg::op_xm_rd: rdata_d = external_data_ram[bus.addr[XA-1:0]];
            flash_pkg::op_code_rd: rdata_d = flash_mem[bus.addr[FA-1:0]];
          endcase
        end
      end
      st_prog: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == 16'(PROG_CYCLES - 1)) begin
          fl_we   = 1'b1;
          // AND with old content: programming never raises a bit
          fl_wd   = flash_mem[tgt_q] & dat_q;
          state_d = st_idle;
          done_d  = 1'b1;
        end
      end
      st_erase: begin
        // One byte per cycle, so the page walk is the erase time
        fl_we   = 1'b1;
        fl_wa   = tgt_q | FA'(cnt_q[`PAGE_BITS-1:0]);
        fl_wd   = `ERASED_BYTE;
        cnt_d   = cnt_q + 16'h0001;
        if (cnt_q == 16'(`PAGE_BYTES - 1)) begin
          state_d = st_idle;
          done_d  = 1'b1;
        end
      end
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= st_idle;
      cnt_q   <= 16'h0000;
      tgt_q   <= '0;
      dat_q   <= 8'h00;
      program_store_write_enable_q   <= `CTRL_RESET;
      program_store_erase_enable_q   <= `CTRL_RESET;
      flash_erase_write_timing_bit_q <= `CTRL_RESET;
      rdata_q <= 8'h00;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      tgt_q   <= tgt_d;
      dat_q   <= dat_d;
      program_store_write_enable_q   <= program_store_write_enable_d;
      program_store_erase_enable_q   <= program_store_erase_enable_d;
      flash_erase_write_timing_bit_q <= flash_erase_write_timing_bit_d;
      rdata_q <= rdata_d;
      done_q  <= done_d;
    end
  end

  // Arrays carry no reset; flash content survives system reset
  always_ff @(posedge hclk) begin
    if (fl_we) flash_mem[fl_wa] <= fl_wd;
    if (xr_we) external_data_ram[xr_wa] <= xr_wd;
  end

  assign bus.stall  = (state_q != st_idle);
  assign bus.rdata  = rdata_q;
  assign bus.program_store_write_enable   = program_store_write_enable_q;
  assign bus.program_store_erase_enable   = program_store_erase_enable_q;
  assign bus.flash_erase_write_timing_bit = flash_erase_write_timing_bit_q;
  assign bus.armed  = armed;
  assign bus.dead   = dead;
  assign flash_busy = (state_q != st_idle);
  assign op_done    = done_q;
  assign lock_dead  = dead;
endmodule : flash_device

// ---- verilog/flash_core.sv ----
`timescale 1ns/10ps
`include "flash_cfg.svh"
module flash_core (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  flash_if.core            bus,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  typedef enum logic [1:0] {hs_idle, hs_issue, hs_wait} core_state_t;

  core_state_t     state_q;
  core_state_t     state_d;
  logic            wpend_q;
  logic            wpend_d;
  logic [7:0]      waddr_q;
  logic [7:0]      waddr_d;
  logic [15:0]     addr_q;
  logic [15:0]     addr_d;
  logic [7:0]      wdata_q;
  logic [7:0]      wdata_d;
  flash_pkg::op_t  op_q;
  flash_pkg::op_t  op_d;
  flash_pkg::sfr_t sel_q;
  flash_pkg::sfr_t sel_d;
  logic            short_q;
  logic            short_d;
  logic [7:0]      rd_q;
  logic [7:0]      rd_d;
  logic [31:0]     hrdata_q;
  logic [31:0]     hrdata_d;
  logic            aphase;

  assign aphase = hsel && htrans[1] && hready;

  function automatic logic [31:0] status_word(input logic busy, input logic [7:0] rd);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`ST_BUSY_BIT]  = busy;
    w[`ST_WRITE_EN_BIT] = bus.program_store_write_enable;
    w[`ST_ERASE_EN_BIT] = bus.program_store_erase_enable;
    w[`ST_TIMING_BIT]   = bus.flash_erase_write_timing_bit;
    w[`ST_ARMED_BIT] = bus.armed;
    w[`ST_DEAD_BIT]  = bus.dead;
    w[`ST_RDATA_LSB +: 8] = rd;
    return w;
  endfunction : status_word

  always_comb begin
    state_d  = state_q;
    wpend_d  = aphase && hwrite;
    waddr_d  = aphase ? haddr[7:0] : waddr_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    op_d     = op_q;
    sel_d    = sel_q;
    short_d  = short_q;
    rd_d     = rd_q;
    hrdata_d = hrdata_q;
    if (aphase && !hwrite) begin
      unique case (haddr[7:0])
        `REG_ADDR:   hrdata_d = {16'h0000, addr_q};
        `REG_WDATA:  hrdata_d = {24'h000000, wdata_q};
        `REG_STATUS: hrdata_d = status_word(state_q != hs_idle, rd_q);
        default:     hrdata_d = 32'h0000_0000;
      endcase
    end
    // Writes to the order registers while busy are dropped
    if (wpend_q && state_q == hs_idle) begin
      unique case (waddr_q)
        `REG_ADDR:  addr_d = hwdata[15:0];
        `REG_WDATA: wdata_d = hwdata[7:0];
        `REG_CMD: begin
          op_d    = flash_pkg::op_t'(hwdata[`CMD_OP_LSB +: 2]);
          sel_d   = flash_pkg::sfr_t'(hwdata[`CMD_SEL_LSB +: 2]);
          short_d = hwdata[`CMD_SHORT_BIT];
          state_d = hs_issue;
        end
        default: ;
      endcase
    end
    unique case (state_q)
      hs_idle: ;
      // Held until the device is free to take it
      hs_issue: if (!bus.stall) state_d = hs_wait;
      hs_wait: begin
        if (!bus.stall) begin
          rd_d    = bus.rdata;
          state_d = hs_idle;
        end
      end
      default: state_d = hs_idle;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q  <= hs_idle;
      wpend_q  <= 1'b0;
      waddr_q  <= 8'h00;
      addr_q   <= 16'h0000;
      wdata_q  <= 8'h00;
      op_q     <= flash_pkg::op_sfr_wr;
      sel_q    <= flash_pkg::sfr_key;
      short_q  <= 1'b0;
      rd_q     <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      state_q  <= state_d;
      wpend_q  <= wpend_d;
      waddr_q  <= waddr_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      op_q     <= op_d;
      sel_q    <= sel_d;
      short_q  <= short_d;
      rd_q     <= rd_d;
      hrdata_q <= hrdata_d;
    end
  end

  // Key order, enables and timing bit are software's duty
  assign bus.req        = (state_q == hs_issue);
  assign bus.op         = op_q;
  assign bus.sel        = sel_q;
  assign bus.addr       = addr_q;
  assign bus.wdata      = wdata_q;
  assign bus.short_form = short_q;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = hrdata_q;
endmodule : flash_core

// ---- verification/flash_chk.sv ----
`timescale 1ns/10ps
module flash_chk #(
  parameter int PROG_CYCLES = 16
) (
  input wire logic            hclk,
  input wire logic            hresetn,
  input wire logic            req,
  input wire flash_pkg::op_t  op,
  input wire flash_pkg::sfr_t sel,
  input wire logic [15:0]     addr,
  input wire logic [7:0]      wdata,
  input wire logic            short_form,
  input wire logic            stall,
  input wire logic            program_store_write_enable,
  input wire logic            program_store_erase_enable,
  input wire logic            armed,
  input wire logic            dead
);
  logic       take;
  logic       fwr;
  logic       hi;
  logic       key;
  logic [9:0] run_q;
  logic [9:0] run_d;
  logic       era_q;
  logic       era_d;
  assign take = req && !stall;
  assign fwr  = take && op == flash_pkg::op_xm_wr && program_store_write_enable;
  assign hi   = short_form && addr > 16'h00ff;
  assign key  = take && op == flash_pkg::op_sfr_wr && sel == flash_pkg::sfr_key;
  // Stall run length and kind of the running operation
  always_comb begin
    run_d = stall ? run_q + 10'h001 : 10'h000;
    era_d = (fwr && !hi && armed && !dead) ? program_store_erase_enable : era_q;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 10'h000;
      era_q <= 1'b0;
    end else begin
      run_q <= run_d;
      era_q <= era_d;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_go;
    fwr && !hi && armed && !dead;
  endsequence
  sequence s_bad;
    fwr && !hi && !dead && !armed;
  endsequence
  a_op_stalls: assert property (s_go |=> stall)
    else $error("armed flash write did not stall");
  a_stall_len: assert property ($fell(stall) |-> run_q == (era_q ? 10'h200 : 10'(PROG_CYCLES)))
    else $error("stall length wrong");
  a_key_kills: assert property (s_bad |=> dead)
    else $error("unkeyed flash write left lock alive");
  a_lock_closes: assert property (s_go |=> !armed)
    else $error("lock stayed open after operation");
  a_refused_quiet: assert property (take && op == flash_pkg::op_xm_wr
      && (!program_store_write_enable || hi || dead) |=> !stall)
    else $error("refused or ram write stalled");
  a_dead_sticky: assert property (dead |=> dead)
    else $error("disable released without reset");
  a_wrong_key: assert property (key && !dead && wdata != 8'ha5 && wdata != 8'hf1 |=> dead)
    else $error("wrong key accepted");
  a_arm_cause: assert property ($rose(armed) |-> $past(key && wdata == 8'hf1))
    else $error("armed without second key");
  a_enable_holds: assert property (!(take && op == flash_pkg::op_sfr_wr && sel == flash_pkg::sfr_ctrl)
      |=> $stable(program_store_write_enable))
    else $error("write enable changed by itself");
endmodule : flash_chk

// ---- verification/flash_program_erase_control_bench.sv ----
`timescale 1ns/10ps
`include "flash_cfg.svh"
module flash_program_erase_control_bench;
  localparam flash_pkg::op_t  os = flash_pkg::op_sfr_wr;
  localparam flash_pkg::op_t  ox = flash_pkg::op_xm_wr;
  localparam flash_pkg::op_t  orr = flash_pkg::op_xm_rd;
  localparam flash_pkg::op_t  oc = flash_pkg::op_code_rd;
  localparam flash_pkg::sfr_t sk = flash_pkg::sfr_key;
  localparam flash_pkg::sfr_t sc = flash_pkg::sfr_ctrl;
  localparam flash_pkg::sfr_t ss = flash_pkg::sfr_scale;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, lock_dead, flash_busy, op_done;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, seed, r, v, w;
  logic        m_wen, m_een, m_ewt, m_armed, m_dead;
  logic [7:0]  fl [int];
  logic [7:0]  xr [int];
  logic [31:0] m_busy, busy_cyc, m_done, dones;
  int          mismatches, comparisons, cyc, kst, i;
  flash_if link ();
  flash_core u_flash_core (.hclk(hclk), .hresetn(hresetn), .bus(link), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata));
  flash_device #(.PROG_CYCLES(16)) u_flash_device (.hclk(hclk), .hresetn(hresetn), .bus(link),
    .flash_busy(flash_busy), .op_done(op_done), .lock_dead(lock_dead));
  flash_chk #(.PROG_CYCLES(16)) u_chk (.hclk(hclk), .hresetn(hresetn), .req(link.req), .op(link.op),
    .sel(link.sel), .addr(link.addr), .wdata(link.wdata), .short_form(link.short_form),
    .stall(link.stall), .program_store_write_enable(link.program_store_write_enable),
    .program_store_erase_enable(link.program_store_erase_enable), .armed(link.armed), .dead(link.dead));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("unexpected cycle count exp below %0d got %0d", 20000, cyc);
      end_sim();
    end
  end
  // Sampled mid-cycle, where busy and done have settled
  always @(negedge hclk) begin
    busy_cyc += flash_busy;
    dones += op_done;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic end_sim();
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic chk_st(logic [5:0] ex, logic [5:0] got);
    comparisons++;
    if (got !== ex) begin
      mismatches++;
      $display("unexpected status exp %h got %h", ex, got);
    end
  endtask : chk_st
  task automatic chk_rd(logic [7:0] ex, logic [7:0] got);
    comparisons++;
    if (got !== ex) begin
      mismatches++;
      $display("unexpected read byte exp %h got %h", ex, got);
    end
  endtask : chk_rd
  task automatic chk_cnt(string what, logic [31:0] ex, logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      mismatches++;
      $display("unexpected %s exp %0d got %0d", what, ex, got);
    end
  endtask : chk_cnt
  task automatic ahb(bit wr, logic [31:0] a, logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic rst();
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    {m_wen, m_een, m_ewt, m_armed, m_dead} = 5'h00;
    kst = 0;
  endtask : rst
  // Model step first, then poll busy; flash content survives reset
  task automatic order(flash_pkg::op_t o, flash_pkg::sfr_t s, logic [15:0] a, logic [7:0] d, bit sh);
    int n;
    ahb(1'b1, {24'h0, `REG_ADDR}, {16'h0, a});
    ahb(1'b1, {24'h0, `REG_WDATA}, {24'h0, d});
    ahb(1'b1, {24'h0, `REG_CMD}, {23'h0, sh, 2'b00, s, 2'b00, o});
    if (o == os && s == sk && !m_dead) begin
      if (m_armed || (kst == 0 && d != 8'ha5) || (kst == 1 && d != 8'hf1)) begin
        m_dead = 1'b1;
        m_armed = 1'b0;
      end else if (kst == 0) kst = 1;
      else begin
        kst = 0;
        m_armed = 1'b1;
      end
    end
    if (o == os && s == sc) {m_een, m_wen} = d[1:0];
    if (o == os && s == ss) m_ewt = d[4];
    if (o == ox && !m_wen) xr[a % 2048] = d;
    else if (o == ox && !(sh && a > 16'h00ff) && !m_dead) begin
      if (!m_armed) m_dead = 1'b1;
      else begin
        m_done++;
        if (m_een) begin
          for (n = 0; n < 512; n++) fl[{a[15:9], 9'h000} + n] = 8'hff;
          m_busy += 512;
        end else begin
          fl[a] = fl[a] & d;
          m_busy += 16;
        end
      end
      m_armed = 1'b0;
    end
    // No poll limit: only the cycle ceiling ends a hang
    do ahb(1'b0, {24'h0, `REG_STATUS}, 32'h0);
    while (r[0] !== 1'b0);
    chk_st({m_dead, m_dead, m_armed, m_ewt, m_een, m_wen}, {lock_dead, r[5:1]});
    chk_cnt("busy cycles", m_busy, busy_cyc);
    chk_cnt("done pulses", m_done, dones);
    if (o == orr) chk_rd(xr[a % 2048], r[15:8]);
    if (o == oc) chk_rd(fl[a], r[15:8]);
  endtask : order
  // Sequences run back to back; nothing can interrupt them
  task automatic key(logic [7:0] a, logic [7:0] b);
    order(os, sk, 16'h0, a, 1'b0);
    order(os, sk, 16'h0, b, 1'b0);
  endtask : key
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    seed = 32'ha3e0;
    {mismatches, comparisons, cyc} = '0;
    {m_busy, busy_cyc, m_done, dones} = '0;
    rst();
    order(os, ss, 16'h0, 8'h10, 1'b0);
    order(os, sc, 16'h0, 8'h03, 1'b0);
    key(8'ha5, 8'hf1);
    v = xs();
    order(ox, sk, {7'h01, v[8:0]}, v[16:9], 1'b0);
    for (i = 0; i < 4; i++) begin
      v = xs();
      order(oc, sk, {7'h01, v[8:0]}, 8'h00, 1'b0);
    end
    order(os, sc, 16'h0, 8'h01, 1'b0);
    v = xs();
    for (i = 0; i < 2; i++) begin
      order(os, sk, 16'h0, 8'ha5, 1'b0);
      repeat (40) @(posedge hclk);
      order(os, sk, 16'h0, 8'hf1, 1'b0);
      w = xs();
      order(ox, sk, {7'h01, v[8:0]}, w[7:0], 1'b0);
      order(oc, sk, {7'h01, v[8:0]}, 8'h00, 1'b0);
    end
    key(8'ha5, 8'hf1);
    order(ox, sk, 16'h0240, 8'h00, 1'b1);
    order(ox, sk, 16'h0240, 8'h5c, 1'b0);
    order(oc, sk, 16'h0240, 8'h00, 1'b0);
    order(os, sc, 16'h0, 8'h02, 1'b0);
    w = xs();
    order(ox, sk, 16'h0300, w[7:0], 1'b0);
    order(orr, sk, 16'h0300, 8'h00, 1'b0);
    order(oc, sk, 16'h0300, 8'h00, 1'b0);
    order(os, sc, 16'h0, 8'h01, 1'b0);
    order(ox, sk, 16'h0210, 8'h00, 1'b0);
    key(8'ha5, 8'hf1);
    order(ox, sk, 16'h0210, 8'h00, 1'b0);
    order(oc, sk, 16'h0210, 8'h00, 1'b0);
    rst();
    order(os, sk, 16'h0, 8'h5a, 1'b0);
    rst();
    key(8'hf1, 8'ha5);
    rst();
    key(8'ha5, 8'hf1);
    order(os, sk, 16'h0, 8'ha5, 1'b0);
    end_sim();
  end
endmodule : flash_program_erase_control_bench
